/* inc/pcr_pkg.sv */
package pcr_pkg;
    // bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_CONTROL = 8'h36;
    localparam logic [7:0] IDX_BANDWIDTH = 8'h37;
    localparam logic [7:0] IDX_MUL_HIGH = 8'h38;
    localparam logic [7:0] IDX_MUL_LOW = 8'h39;
    localparam logic [7:0] IDX_RANGE = 8'h3a;
    localparam logic [ADDR_W-1:0] ADDR_CONTROL = ADDR_W'(IDX_CONTROL * 4);
    localparam logic [ADDR_W-1:0] ADDR_BANDWIDTH = ADDR_W'(IDX_BANDWIDTH * 4);
    localparam logic [ADDR_W-1:0] ADDR_MUL_HIGH = ADDR_W'(IDX_MUL_HIGH * 4);
    localparam logic [ADDR_W-1:0] ADDR_MUL_LOW = ADDR_W'(IDX_MUL_LOW * 4);
    localparam logic [ADDR_W-1:0] ADDR_RANGE = ADDR_W'(IDX_RANGE * 4);

    // control register fields
    localparam int BIT_IRQ_EN = 7;
    localparam int BIT_FLAG = 6;
    localparam int BIT_POWER_ON = 5;
    localparam int BIT_BASE_SEL = 4;
    localparam int BIT_EXP_HI = 1;
    localparam int BIT_EXP_LO = 0;

    // bandwidth register fields
    localparam int BIT_AUTO = 7;
    localparam int BIT_LOCK = 6;
    localparam int BIT_CAPTURE = 5;

    // reset values
    localparam logic RST_POWER_ON = 1'b1;
    localparam logic [1:0] RST_EXPONENT = 2'h0;
    localparam logic [3:0] RST_MUL_HIGH = 4'h0;
    localparam logic [7:0] RST_MUL_LOW = 8'h40;
    localparam logic [7:0] RST_RANGE = 8'h40;
    localparam logic [11:0] MUL_ONE = 12'h001;

    // clock switch-over: edges of each source before the change
    localparam int SWITCH_EDGES = 3;

    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* verilog/pcr_sync.sv */
// two-flop synchroniser for a bundle of asynchronous levels
module pcr_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    // first stage is read only by the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

/* verilog/pcr_edge_count.sv */
// rising-edge detector with a saturating edge counter
module pcr_edge_count #(
    parameter int N = 3
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic level,
    input wire logic clear,
    output logic rise,
    output logic done
);
    localparam int CW = $clog2(N + 1);
    logic prev;
    logic [CW-1:0] count;

    assign rise = level & ~prev;
    assign done = (count == CW'(N));

    // count saturates so a dead source simply never completes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev <= 1'b0;
            count <= '0;
        end else begin
            prev <= level;
            if (clear) begin
                count <= '0;
            end else if (rise && !done) begin
                count <= count + CW'(1);
            end
        end
    end
endmodule

/* verilog/pll_control_registers.sv */
// Operation
// - irq enable writable only in auto mode, else reads 0; reset clears.
// - flag sets on every lock toggle in auto mode; irq while flag and enable both set.
// - flag reads 0 while auto mode is off; reset clears it.
// - a read of the control register clears the lock-change flag unless a toggle comes in the same cycle.
// - power-on cannot clear while vco is base source; reset sets it.
// - base select 1 gives vco/2, 0 gives crystal/2; reset clears.
// - base select cannot be set while power-on is clear.
// - output holds until both clocks have shown three edges, then switches.
// - exponent 00 gives 1, 01 gives 2, 10 gives 4; never write 3.
// - exponent ignores writes while powered on; reset clears it.
// - bandwidth mode 1 is automatic, 0 manual; reset gives manual.
// - lock status read-only in auto, reads 0 in manual; reset clears.
// - capture bit is status in auto, writable control in manual.
// - last manual capture value is held through auto mode and restored.
// - a multiplier of zero behaves exactly as a multiplier of one.
// - multiplier resets to 64: high part zero, low part 0x40.
// - multiplier ignores writes while powered; high nibble above reads 0.
// - range ignores writes while on; zero disables loop and base select.
// - range register resets to 64.
module pll_control_registers (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic [pcr_pkg::ADDR_W-1:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [pcr_pkg::DATA_W-1:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [pcr_pkg::ADDR_W-1:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [pcr_pkg::DATA_W-1:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    input wire logic LOCK_DETECT,
    input wire logic TRACKING_DETECT,
    input wire logic CRYSTAL_CLOCK,
    input wire logic VCO_CLOCK,
    output logic BASE_CLOCK_OUT,
    output logic LOCK_IRQ,
    output logic LOOP_ENABLE,
    output logic AUTO_BANDWIDTH,
    output logic CAPTURE_MODE,
    output logic [1:0] RANGE_EXPONENT,
    output logic [7:0] RANGE_LINEAR,
    output logic [11:0] MULTIPLIER
);
    typedef enum logic {
        SW_RUN,
        SW_HOLD
    } pcr_switch_t;

    logic rst_meta;
    logic rst_n;
    logic [3:0] sync_out;
    logic lock_s;
    logic track_s;
    logic xclk_s;
    logic vclk_s;
    logic lock_prev;
    logic lock_toggle;

    logic [pcr_pkg::ADDR_W-1:0] waddr;
    logic [7:0] wbyte;
    logic wlane;
    logic aw_hs;
    logic w_hs;
    logic ar_hs;
    logic wr_en;
    logic wr_ctrl;
    logic wr_bw;
    logic wr_mhi;
    logic wr_mlo;
    logic wr_rng;
    logic rd_ctrl;

    logic irq_enable;
    logic lock_flag;
    logic power_on;
    logic base_sel;
    logic [1:0] exponent;
    logic auto_mode;
    logic capture_hold;
    logic [3:0] mul_high;
    logic [7:0] mul_low;
    logic [7:0] range_linear;
    logic range_zero;
    logic [11:0] mul_raw;

    logic [7:0] ctrl_view;
    logic [7:0] bw_view;
    logic [7:0] next_rbyte;
    logic next_rhit;

    pcr_switch_t sw_state;
    logic active_sel;
    logic x_rise;
    logic v_rise;
    logic x_done;
    logic v_done;
    logic sw_clear;

    ////////////////////////////////////////////////////////////////////////
    // reset release through two flops; assertion stays asynchronous
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pins from the analog side and the two source clocks
    pcr_sync #(
        .W(4)
    ) u_sync (
        .clk(CLK),
        .rst_n(rst_n),
        .d({VCO_CLOCK, CRYSTAL_CLOCK, TRACKING_DETECT, LOCK_DETECT}),
        .q(sync_out)
    );

    assign lock_s = sync_out[0];
    assign track_s = sync_out[1];
    assign xclk_s = sync_out[2];
    assign vclk_s = sync_out[3];
    assign lock_toggle = lock_s ^ lock_prev;

    // previous synchronised lock level for toggle detection
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            lock_prev <= 1'b0;
        end else begin
            lock_prev <= lock_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // write channels: address and data taken in either order
    assign aw_hs = AWVALID & AWREADY;
    assign w_hs = WVALID & WREADY;
    assign wr_en = ~AWREADY & ~WREADY & ~BVALID;

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            AWREADY <= 1'b1;
            waddr <= '0;
        end else if (aw_hs) begin
            AWREADY <= 1'b0;
            waddr <= AWADDR;
        end else if (BVALID && BREADY) begin
            AWREADY <= 1'b1;
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            WREADY <= 1'b1;
            wbyte <= '0;
            wlane <= 1'b0;
        end else if (w_hs) begin
            WREADY <= 1'b0;
            wbyte <= WDATA[7:0];
            wlane <= WSTRB[0];
        end else if (BVALID && BREADY) begin
            WREADY <= 1'b1;
        end
    end

    // response follows once both halves are held
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            BVALID <= 1'b0;
            BRESP <= pcr_pkg::RESP_OKAY;
        end else if (wr_en) begin
            BVALID <= 1'b1;
            BRESP <= (wr_ctrl | wr_bw | wr_mhi | wr_mlo | wr_rng
                      | ~wlane) ? pcr_pkg::RESP_OKAY : pcr_pkg::RESP_SLVERR;
        end else if (BREADY) begin
            BVALID <= 1'b0;
        end
    end

    // decode; a write without the low byte lane stores nothing
    always_comb begin
        wr_ctrl = wr_en & wlane & (waddr == pcr_pkg::ADDR_CONTROL);
        wr_bw = wr_en & wlane & (waddr == pcr_pkg::ADDR_BANDWIDTH);
        wr_mhi = wr_en & wlane & (waddr == pcr_pkg::ADDR_MUL_HIGH);
        wr_mlo = wr_en & wlane & (waddr == pcr_pkg::ADDR_MUL_LOW);
        wr_rng = wr_en & wlane & (waddr == pcr_pkg::ADDR_RANGE);
    end

    ////////////////////////////////////////////////////////////////////////
    // control register
    assign range_zero = (range_linear == 8'h00);

    // interrupt enable only takes writes in automatic mode
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            irq_enable <= 1'b0;
        end else if (wr_ctrl && auto_mode) begin
            irq_enable <= wbyte[pcr_pkg::BIT_IRQ_EN];
        end
    end

    // set beats the read-clear so a toggle during a read is not lost
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            lock_flag <= 1'b0;
        end else if (!auto_mode) begin
            lock_flag <= 1'b0;
        end else if (lock_toggle) begin
            lock_flag <= 1'b1;
        end else if (rd_ctrl) begin
            lock_flag <= 1'b0;
        end
    end

    // old select value guards the clear: off and a switch to vco can pair in one write
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            power_on <= pcr_pkg::RST_POWER_ON;
        end else if (wr_ctrl) begin
            power_on <= wbyte[pcr_pkg::BIT_POWER_ON] | base_sel;
        end
    end

    // vco source needs the loop already on and a nonzero range
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            base_sel <= 1'b0;
        end else if (range_zero) begin
            base_sel <= 1'b0;
        end else if (wr_ctrl) begin
            base_sel <= wbyte[pcr_pkg::BIT_BASE_SEL] & power_on;
        end
    end

    // exponent frozen while the loop runs
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            exponent <= pcr_pkg::RST_EXPONENT;
        end else if (wr_ctrl && !power_on) begin
            exponent <= {wbyte[pcr_pkg::BIT_EXP_HI],
                         wbyte[pcr_pkg::BIT_EXP_LO]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bandwidth register; lock position is written as zero and ignored
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            auto_mode <= 1'b0;
        end else if (wr_bw) begin
            auto_mode <= wbyte[pcr_pkg::BIT_AUTO];
        end
    end

    // manual capture value survives automatic mode untouched
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            capture_hold <= 1'b0;
        end else if (wr_bw && !auto_mode) begin
            capture_hold <= wbyte[pcr_pkg::BIT_CAPTURE];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // multiplier and range, all frozen while the loop is on
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            mul_high <= pcr_pkg::RST_MUL_HIGH;
        end else if (wr_mhi && !power_on) begin
            mul_high <= wbyte[3:0];
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            mul_low <= pcr_pkg::RST_MUL_LOW;
        end else if (wr_mlo && !power_on) begin
            mul_low <= wbyte;
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            range_linear <= pcr_pkg::RST_RANGE;
        end else if (wr_rng && !power_on) begin
            range_linear <= wbyte;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read channel; one read at a time, data one cycle after the address
    assign ar_hs = ARVALID & ARREADY;
    assign rd_ctrl = ar_hs & (ARADDR == pcr_pkg::ADDR_CONTROL);

    always_comb begin
        ctrl_view = 8'h00;
        ctrl_view[pcr_pkg::BIT_IRQ_EN] = irq_enable & auto_mode;
        ctrl_view[pcr_pkg::BIT_FLAG] = lock_flag & auto_mode;
        ctrl_view[pcr_pkg::BIT_POWER_ON] = power_on;
        ctrl_view[pcr_pkg::BIT_BASE_SEL] = base_sel;
        ctrl_view[pcr_pkg::BIT_EXP_HI] = exponent[1];
        ctrl_view[pcr_pkg::BIT_EXP_LO] = exponent[0];
    end

    // status bits come from the loop in auto mode; in manual, capture comes from software and lock reads 0
    always_comb begin
        bw_view = 8'h00;
        bw_view[pcr_pkg::BIT_AUTO] = auto_mode;
        bw_view[pcr_pkg::BIT_LOCK] = lock_s & auto_mode;
        bw_view[pcr_pkg::BIT_CAPTURE] = auto_mode ? track_s
                                                  : capture_hold;
    end

    always_comb begin
        next_rhit = 1'b1;
        case (ARADDR)
            pcr_pkg::ADDR_CONTROL: next_rbyte = ctrl_view;
            pcr_pkg::ADDR_BANDWIDTH: next_rbyte = bw_view;
            pcr_pkg::ADDR_MUL_HIGH: next_rbyte = {4'h0, mul_high};
            pcr_pkg::ADDR_MUL_LOW: next_rbyte = mul_low;
            pcr_pkg::ADDR_RANGE: next_rbyte = range_linear;
            default: begin
                next_rbyte = 8'h00;
                next_rhit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            ARREADY <= 1'b1;
            RVALID <= 1'b0;
            RDATA <= '0;
            RRESP <= pcr_pkg::RESP_OKAY;
        end else if (ar_hs) begin
            ARREADY <= 1'b0;
            RVALID <= 1'b1;
            RDATA <= {24'h000000, next_rbyte};
            RRESP <= next_rhit ? pcr_pkg::RESP_OKAY : pcr_pkg::RESP_SLVERR;
        end else if (RVALID && RREADY) begin
            ARREADY <= 1'b1;
            RVALID <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // base clock selector; sources are oversampled, so they must stay
    // well below half of the bus clock to be seen cleanly
    pcr_edge_count #(
        .N(pcr_pkg::SWITCH_EDGES)
    ) u_xcount (
        .clk(CLK),
        .rst_n(rst_n),
        .level(xclk_s),
        .clear(sw_clear),
        .rise(x_rise),
        .done(x_done)
    );

    pcr_edge_count #(
        .N(pcr_pkg::SWITCH_EDGES)
    ) u_vcount (
        .clk(CLK),
        .rst_n(rst_n),
        .level(vclk_s),
        .clear(sw_clear),
        .rise(v_rise),
        .done(v_done)
    );

    assign sw_clear = (sw_state == SW_RUN);

    // hold the output still until both sources have shown three edges
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            sw_state <= SW_RUN;
            active_sel <= 1'b0;
        end else begin
            case (sw_state)
                SW_RUN: begin
                    if (base_sel != active_sel) begin
                        sw_state <= SW_HOLD;
                    end
                end
                SW_HOLD: begin
                    if (x_done && v_done) begin
                        active_sel <= base_sel;
                        sw_state <= SW_RUN;
                    end
                end
                default: sw_state <= SW_RUN;
            endcase
        end
    end

    // divide the chosen source by two; frozen in stasis
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            BASE_CLOCK_OUT <= 1'b0;
        end else if (sw_state == SW_RUN) begin
            if (active_sel ? v_rise : x_rise) begin
                BASE_CLOCK_OUT <= ~BASE_CLOCK_OUT;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registered outputs to the loop
    assign mul_raw = {mul_high, mul_low};

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            LOCK_IRQ <= 1'b0;
            LOOP_ENABLE <= 1'b0;
            AUTO_BANDWIDTH <= 1'b0;
            CAPTURE_MODE <= 1'b0;
            RANGE_EXPONENT <= 2'h0;
            RANGE_LINEAR <= 8'h00;
            MULTIPLIER <= pcr_pkg::MUL_ONE;
        end else begin
            LOCK_IRQ <= lock_flag & irq_enable & auto_mode;
            LOOP_ENABLE <= power_on & ~range_zero;
            AUTO_BANDWIDTH <= auto_mode;
            CAPTURE_MODE <= capture_hold;
            RANGE_EXPONENT <= exponent;
            RANGE_LINEAR <= range_linear;
            MULTIPLIER <= (mul_raw == 12'h000) ? pcr_pkg::MUL_ONE
                                               : mul_raw;
        end
    end
endmodule

/* test/pcr_checker.sv */
module pcr_checker (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic AWVALID,
    input wire logic AWREADY,
    input wire logic WVALID,
    input wire logic WREADY,
    input wire logic BVALID,
    input wire logic [pcr_pkg::ADDR_W-1:0] ARADDR,
    input wire logic ARVALID,
    input wire logic ARREADY,
    input wire logic [pcr_pkg::DATA_W-1:0] RDATA,
    input wire logic [1:0] RRESP,
    input wire logic RVALID,
    input wire logic BASE_CLOCK_OUT,
    input wire logic LOCK_IRQ,
    input wire logic LOOP_ENABLE,
    input wire logic AUTO_BANDWIDTH,
    input wire logic [1:0] RANGE_EXPONENT,
    input wire logic [7:0] RANGE_LINEAR,
    input wire logic [11:0] MULTIPLIER
);
    timeunit 1ns;
    timeprecision 1ps;
    // one clock domain, so one default for all properties
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    ////////////////////////////////////////
    AST_IRQ_MANUAL: assert property (!AUTO_BANDWIDTH [*2] |-> !LOCK_IRQ)
        else $error("irq raised in manual mode");
    AST_LOOP_RANGE: assert property (LOOP_ENABLE |-> RANGE_LINEAR != 8'h00)
        else $error("loop enabled with zero range");
    AST_MUL_NONZERO: assert property (MULTIPLIER != 12'h000)
        else $error("multiplier of zero reached the loop");
    // protected settings must not move while the loop runs
    AST_FROZEN: assert property (LOOP_ENABLE |=> $stable(MULTIPLIER)
        && $stable(RANGE_LINEAR) && $stable(RANGE_EXPONENT))
        else $error("setting changed while loop on");
    AST_WR_ANSWER: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID)
        else $error("write answer late");
    AST_RD_ANSWER: assert property (ARVALID && ARREADY |=> RVALID)
        else $error("read answer late");
    AST_RD_UNMAPPED: assert property (ARVALID && ARREADY && ARADDR == 8'h00
        |=> RRESP == pcr_pkg::RESP_SLVERR && RDATA == 32'h0)
        else $error("unmapped read not refused");
    AST_ONE_READ: assert property (RVALID |-> !ARREADY)
        else $error("second read accepted");
    // divide by two of a source slower than half the bus clock
    AST_DIVIDE: assert property ($changed(BASE_CLOCK_OUT) |=> $stable(BASE_CLOCK_OUT))
        else $error("base clock toggled twice in a row");
    CVR_IRQ: cover property ($rose(LOCK_IRQ));
    CVR_CLOCK: cover property ($changed(BASE_CLOCK_OUT));
    CVR_REFUSED: cover property (RVALID && RRESP == pcr_pkg::RESP_SLVERR);
endmodule
////////////////////////////////////////
bind pll_control_registers pcr_checker i_chk (.CLK(CLK), .RESET_N(RESET_N),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY),
    .BVALID(BVALID), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .BASE_CLOCK_OUT(BASE_CLOCK_OUT),
    .LOCK_IRQ(LOCK_IRQ), .LOOP_ENABLE(LOOP_ENABLE), .AUTO_BANDWIDTH(AUTO_BANDWIDTH),
    .RANGE_EXPONENT(RANGE_EXPONENT), .RANGE_LINEAR(RANGE_LINEAR), .MULTIPLIER(MULTIPLIER));

/* test/pll_control_registers_tb.sv */
module pll_control_registers_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] A_C = pcr_pkg::ADDR_CONTROL;
    localparam logic [7:0] A_B = pcr_pkg::ADDR_BANDWIDTH;
    localparam logic [7:0] A_H = pcr_pkg::ADDR_MUL_HIGH;
    localparam logic [7:0] A_L = pcr_pkg::ADDR_MUL_LOW;
    localparam logic [7:0] A_R = pcr_pkg::ADDR_RANGE;
    logic CLK = 1'h0, RESET_N = 1'h0, AWVALID = 1'h0, WVALID = 1'h0, BREADY = 1'h0;
    logic ARVALID = 1'h0, RREADY = 1'h0, LOCK_DETECT = 1'h0, TRACKING_DETECT = 1'h0;
    logic [7:0] AWADDR = 8'h0, ARADDR = 8'h0;
    logic [31:0] WDATA = 32'h0;
    logic [3:0] WSTRB = 4'hf;
    logic [2:0] ph = 3'h0;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, BASE_CLOCK_OUT, LOCK_IRQ, LOOP_ENABLE;
    logic AUTO_BANDWIDTH, CAPTURE_MODE;
    logic [1:0] BRESP, RRESP, RANGE_EXPONENT;
    logic [31:0] RDATA;
    logic [7:0] RANGE_LINEAR;
    logic [11:0] MULTIPLIER;
    int fails = 0, checks_done = 0;
    int c;

    pll_control_registers i_dut (.CLK(CLK), .RESET_N(RESET_N), .AWADDR(AWADDR),
        .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
        .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
        .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
        .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
        .LOCK_DETECT(LOCK_DETECT), .TRACKING_DETECT(TRACKING_DETECT),
        .CRYSTAL_CLOCK(ph[2]), .VCO_CLOCK(ph[1]), .BASE_CLOCK_OUT(BASE_CLOCK_OUT),
        .LOCK_IRQ(LOCK_IRQ), .LOOP_ENABLE(LOOP_ENABLE), .AUTO_BANDWIDTH(AUTO_BANDWIDTH),
        .CAPTURE_MODE(CAPTURE_MODE), .RANGE_EXPONENT(RANGE_EXPONENT),
        .RANGE_LINEAR(RANGE_LINEAR), .MULTIPLIER(MULTIPLIER));
    ////////////////////////////////////////
    // bus clock, plus source clocks at a quarter and an eighth of it
    always #2.5 CLK = ~CLK;
    always @(posedge CLK) ph <= ph + 3'h1;

    task automatic chk(input string n, input logic [31:0] g, e);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    // write one register; waits for the answer, only the watchdog ends a hang
    task automatic w(input logic [7:0] a, d, input logic [1:0] er = pcr_pkg::RESP_OKAY);
        logic [1:0] br;
        br = 2'h1;
        AWADDR <= a;
        WDATA <= {24'h0, d};
        AWVALID <= 1'h1;
        WVALID <= 1'h1;
        BREADY <= 1'h1;
        forever begin
            @(posedge CLK);
            if (AWREADY) AWVALID <= 1'h0;
            if (WREADY) WVALID <= 1'h0;
            if (BVALID) begin
                br = BRESP;
                BREADY <= 1'h0;
                break;
            end
        end
        @(posedge CLK);
        chk("bresp", br, er);
    endtask

    task automatic r(input logic [7:0] a, input logic [31:0] e,
            input logic [1:0] er = pcr_pkg::RESP_OKAY);
        logic [31:0] d;
        logic [1:0] rr;
        d = 32'hdeadbeef;
        rr = 2'h1;
        ARADDR <= a;
        ARVALID <= 1'h1;
        RREADY <= 1'h1;
        forever begin
            @(posedge CLK);
            if (ARREADY) ARVALID <= 1'h0;
            if (RVALID) begin
                d = RDATA;
                rr = RRESP;
                RREADY <= 1'h0;
                break;
            end
        end
        @(posedge CLK);
        chk("rdata", d, e);
        chk("rresp", rr, er);
    endtask

    // counts output transitions over a fixed span
    task automatic tog(output int n);
        logic p;
        n = 0;
        p = BASE_CLOCK_OUT;
        repeat (80) begin
            @(posedge CLK);
            if (BASE_CLOCK_OUT !== p) n++;
            p = BASE_CLOCK_OUT;
        end
    endtask
    ////////////////////////////////////////
    task automatic t_reset;
        r(A_C, 32'h20);
        r(A_B, 32'h0);
        r(A_H, 32'h0);
        r(A_L, 32'h40);
        r(A_R, 32'h40);
        chk("mul", MULTIPLIER, 32'h40);
        chk("range", RANGE_LINEAR, 32'h40);
    endtask

    task automatic t_protect;
        w(A_L, 8'h0);
        r(A_L, 32'h40);
        w(A_R, 8'h0);
        r(A_R, 32'h40);
        w(A_C, 8'h21);
        r(A_C, 32'h20);
        w(A_C, 8'h0);
        r(A_C, 32'h0);
        w(A_C, 8'h10);
        r(A_C, 32'h0);
        w(A_H, 8'hff);
        r(A_H, 32'h0f);
        w(A_H, 8'h0);
        w(A_L, 8'h0);
        chk("mul", MULTIPLIER, 32'h1);
        for (int e = 0; e < 3; e++) begin
            w(A_C, 8'(e));
            r(A_C, 32'(e));
            chk("exp", RANGE_EXPONENT, 32'(e));
        end
        w(A_L, 8'h40);
        w(A_R, 8'h0);
        w(A_C, 8'h20);
        w(A_C, 8'h30);
        r(A_C, 32'h20);
        chk("loop", LOOP_ENABLE, 32'h0);
        w(A_C, 8'h0);
        w(A_R, 8'h40);
        w(A_B, 8'h0);
        w(A_C, 8'h20);
    endtask

    // one write reaches the vco source, a second fails to power off, then back
    task automatic t_clock;
        w(A_C, 8'h30);
        r(A_C, 32'h30);
        w(A_C, 8'h10);
        r(A_C, 32'h30);
        repeat (40) @(posedge CLK);
        tog(c);
        chk("vco", 32'(c inside {[19:21]}), 32'h1);
        w(A_C, 8'h20);
        repeat (40) @(posedge CLK);
        tog(c);
        chk("xtal", 32'(c inside {[9:11]}), 32'h1);
    endtask

    task automatic t_auto;
        w(A_B, 8'h20);
        r(A_B, 32'h20);
        chk("capture", CAPTURE_MODE, 32'h1);
        w(A_C, 8'ha0);
        r(A_C, 32'h20);
        w(A_B, 8'ha0);
        r(A_B, 32'h80);
        chk("auto", AUTO_BANDWIDTH, 32'h1);
        w(A_C, 8'ha0);
        r(A_C, 32'ha0);
        LOCK_DETECT <= 1'h1;
        repeat (6) @(posedge CLK);
        chk("irq", LOCK_IRQ, 32'h1);
        r(A_B, 32'hc0);
        r(A_C, 32'he0);
        r(A_C, 32'ha0);
        chk("irq", LOCK_IRQ, 32'h0);
        TRACKING_DETECT <= 1'h1;
        repeat (4) @(posedge CLK);
        r(A_B, 32'he0);
        LOCK_DETECT <= 1'h0;
        TRACKING_DETECT <= 1'h0;
        repeat (6) @(posedge CLK);
        chk("irq", LOCK_IRQ, 32'h1);
        w(A_B, 8'h0);
        r(A_C, 32'h20);
        chk("irq", LOCK_IRQ, 32'h0);
        r(A_B, 32'h20);
    endtask

    task automatic t_bus;
        w(8'h0, 8'h55, pcr_pkg::RESP_SLVERR);
        r(8'h0, 32'h0, pcr_pkg::RESP_SLVERR);
        // write without the low byte lane must store nothing
        WSTRB <= 4'he;
        w(A_B, 8'h80);
        r(A_B, 32'h20);
        WSTRB <= 4'hf;
    endtask
    ////////////////////////////////////////
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // hang guard, well beyond the expected run length
    initial begin
        repeat (20000) @(posedge CLK);
        fails++;
        give_verdict();
    end

    initial begin
        repeat (12) @(posedge CLK);
        RESET_N <= 1'h1;
        repeat (4) @(posedge CLK);
        t_reset();
        t_protect();
        t_clock();
        t_auto();
        t_bus();
        give_verdict();
    end
endmodule
